// *** hw/irq_ctl_pkg.sv ***
// constants, offsets and types for the interrupt config and cpu interface
package irq_ctl_pkg;
    localparam int          AddrWidth        = 12;
    localparam logic [11:0] OffsCpuCtrl      = 12'h000;
    localparam logic [11:0] OffsPrioThresh   = 12'h004;
    localparam logic [11:0] OffsGroupSplit   = 12'h008;
    localparam logic [11:0] OffsAck          = 12'h00c;
    localparam logic [11:0] OffsCompletion   = 12'h010;
    localparam logic [11:0] OffsActivePrio   = 12'h014;
    localparam logic [11:0] OffsTopPending   = 12'h018;
    localparam logic [11:0] OffsCfgIpi       = 12'hc00;
    localparam logic [11:0] OffsCfg16        = 12'hc04;
    localparam logic [11:0] OffsCfg32        = 12'hc08;
    localparam logic [11:0] OffsCfg48        = 12'hc0c;
    localparam logic [11:0] OffsSoftTrig     = 12'hf00;
    localparam logic [11:0] OffsSoftPending  = 12'hf04;
    localparam logic [11:0] OffsIrqPrio      = 12'hf08;
    localparam logic [31:0] IpiCfgWriteMask  = 32'h55555555;
    localparam logic [31:0] Cfg16Value       = 32'h00000000;
    localparam logic [2:0]  SplitMin         = 3'h3;
    localparam logic [9:0]  SpuriousId       = 10'h3ff;
    localparam logic [7:0]  IdleRunPrio      = 8'hff;
    localparam int          NumIrq           = 64;
    localparam int          NumIpi           = 16;
    localparam int          HwBase           = 32;
    localparam logic [2:0]  OwnCpu           = 3'h0;
    localparam int          IdLsb            = 0;
    localparam int          IdMsb            = 9;
    localparam int          SrcLsb           = 10;
    localparam int          SrcMsb           = 12;
    localparam int          ListLsb          = 16;
    localparam int          FiltLsb          = 24;
    localparam int          PrioLsb          = 4;
    typedef enum logic [1:0] {
        FILT_LIST, FILT_OTHERS, FILT_SELF, FILT_RESV
    } filter_type;
endpackage : irq_ctl_pkg

// *** hw/irq_dist_cfg_cpu_iface.sv ***
// distributor configuration, software trigger and cpu interface
// Functional notes
// - INTER_PROCESSOR_INTERRUPT config: only software-model bits writable
// - config bit 1 set: rising edge input
// - config bit 1 clear: high level input
// - config bit 0 picks handling model
// - config for IDs 16-31 read-only
// - IDs 32-63 config fully writable
// - software trigger: id, filter, target list
// - filter 00: listed processors only
// - filter 01: all but the writer
// - filter 10: writer only; 11 reserved
// - target list comes from write itself
// - control: enable bit 0, reset zero
// - request only if priority beats threshold
// - equal priority to threshold never requests
// - ties: lowest ID, then lowest source
// - split value selects preemption priority bits
// - split clamps to minimum three, resets there
// - acknowledge returns id and source
// - completion write ends running interrupt
// - active priority reads 0xff when idle
// - top pending reads 0x3ff when idle
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module irq_dist_cfg_cpu_iface
    import irq_ctl_pkg::*;
(
    input  wire logic        clk,        // 50 MHz clock
    input  wire logic        rst,        // async reset, high
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [11:0] paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic      [31:0] prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error, unmapped
    input  wire logic [31:0] hwIrqIn,    // hardware lines, IDs 32-63
    output logic             cpuIrqReq   // interrupt request to core
);
    // priority per interrupt id, 0-63, lives in a small local table (4 bits each)
    logic [31:0] cfgIpi, cfg32, cfg48, softPend, hwPend, hwLast;
    logic [3:0]  irqPrio [NumIrq];
    logic        cpuEnable;
    logic [3:0]  prioThresh;
    logic [2:0]  groupSplit;
    logic        running;
    logic [9:0]  runId;
    logic [3:0]  runPrio;
    logic [9:0]  topId;
    logic [3:0]  topPrio;
    logic        topValid;
    logic        access, wr, rd;

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;

    function automatic logic mapped(input logic [11:0] a);
        case (a)
            OffsCpuCtrl, OffsPrioThresh, OffsGroupSplit, OffsAck,
            OffsCompletion, OffsActivePrio, OffsTopPending, OffsCfgIpi,
            OffsCfg16, OffsCfg32, OffsCfg48, OffsSoftTrig,
            OffsSoftPending, OffsIrqPrio: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    // mask of processors reached by a software trigger; one core exists
    function automatic logic [7:0] soft_targets(input logic [31:0] d);
        logic [7:0] self;
        self = 8'h01 << OwnCpu;
        case (filter_type'(d[FiltLsb +: 2]))
            FILT_LIST:   soft_targets = d[ListLsb +: 8];
            FILT_OTHERS: soft_targets = ~self;
            FILT_SELF:   soft_targets = self;
            default:     soft_targets = 8'h00;
        endcase
    endfunction : soft_targets

    // bus slave: zero wait state, error on unmapped address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped(paddr);
        end
    end

    // software-visible control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpuEnable  <= 1'b0;
            prioThresh <= 4'h0;
            groupSplit <= SplitMin;
            cfgIpi     <= 32'h00000000;
            cfg32      <= 32'h00000000;
            cfg48      <= 32'h00000000;
        end else if (wr && pready) begin
            case (paddr)
                OffsCpuCtrl:    cpuEnable  <= pwdata[0];
                OffsPrioThresh: prioThresh <= pwdata[PrioLsb +: 4];
                OffsGroupSplit: groupSplit <= (pwdata[2:0] < SplitMin) ?
                                    SplitMin : pwdata[2:0];
                OffsCfgIpi:     cfgIpi <= pwdata & IpiCfgWriteMask;
                OffsCfg32:      cfg32  <= pwdata;
                OffsCfg48:      cfg48  <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NumIrq; i++) irqPrio[i] <= 4'h0;
        end else if (wr && pready && paddr == OffsIrqPrio) begin
            // priority write carries its id where a target list would sit
            irqPrio[pwdata[ListLsb +: 6]] <= pwdata[PrioLsb +: 4];
        end
    end

    // hardware line sensing; edge events stay latched until acknowledged
    logic [31:0] cfgEdge;
    generate
        for (genvar g = 0; g < 16; g++) begin : g_cfg
            assign cfgEdge[g]      = cfg32[2*g+1];
            assign cfgEdge[g + 16] = cfg48[2*g+1];
        end
    endgenerate

    // id handed out at setup; ack acts on that id even if top moves on
    logic       ackHw, ackSoft, ackValid;
    logic [9:0] ackId;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackId    <= SpuriousId;
            ackValid <= 1'b0;
        end else if (psel && !penable) begin
            ackId    <= topId;
            ackValid <= topValid;
        end
    end
    assign ackHw   = rd && pready && paddr == OffsAck && ackValid &&
                     ackId >= 10'(HwBase);
    assign ackSoft = rd && pready && paddr == OffsAck && ackValid &&
                     ackId < 10'(HwBase);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hwLast <= 32'h00000000;
            hwPend <= 32'h00000000;
        end else begin
            hwLast <= hwIrqIn;
            for (int i = 0; i < 32; i++) begin
                if (cfgEdge[i]) begin
                    if (hwIrqIn[i] && !hwLast[i])
                        hwPend[i] <= 1'b1;
                    else if (ackHw && ackId[4:0] == 5'(i))
                        hwPend[i] <= 1'b0;
                end else begin
                    hwPend[i] <= hwIrqIn[i];
                end
            end
        end
    end

    // one copy of the sensing checks per hardware line
    generate
        for (genvar g = 0; g < NumIrq - HwBase; g++) begin : g_sense
            edge_latch_a: assert property (
                @(posedge clk) disable iff (rst)
                cfgEdge[g] && hwIrqIn[g] && !hwLast[g] |=> hwPend[g])
                else $error("rising edge not latched");
            level_follow_a: assert property (
                @(posedge clk) disable iff (rst)
                !cfgEdge[g] |=> hwPend[g] == $past(hwIrqIn[g]))
                else $error("level line not followed");
        end
    endgenerate

    // software triggers; set wins over the clear by acknowledge
    logic [31:0] trigSet;
    logic [7:0]  softTgt;
    assign softTgt = soft_targets(pwdata);
    always_comb begin
        trigSet = 32'h00000000;
        if (wr && pready && paddr == OffsSoftTrig &&
            softTgt[OwnCpu] &&
            pwdata[IdMsb:IdLsb] < 10'(HwBase))
            trigSet[pwdata[4:0]] = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            softPend <= 32'h00000000;
        end else begin
            for (int i = 0; i < 32; i++) begin
                if (trigSet[i])
                    softPend[i] <= 1'b1;
                else if (ackSoft && ackId[4:0] == 5'(i))
                    softPend[i] <= 1'b0;
            end
        end
    end

    // arbitration: lowest priority value wins, ties to lowest id
    always_comb begin
        topValid = 1'b0;
        topId    = SpuriousId;
        topPrio  = 4'hf;
        for (int i = NumIrq - 1; i >= 0; i--) begin
            if ((i < 32 ? softPend[i % 32] : hwPend[i % 32]) &&
                (!topValid || irqPrio[i] <= topPrio)) begin
                topValid = 1'b1;
                topId    = 10'(i);
                topPrio  = irqPrio[i];
            end
        end
    end

    // preemption compares only priority bits above the split point
    logic [7:0] topP8, runP8, groupMask;
    assign topP8     = {topPrio, 4'h0};
    assign runP8     = {runPrio, 4'h0};
    assign groupMask = 8'hff << (groupSplit + 3'h1);
    logic preempts;
    assign preempts = !running ||
        (groupSplit != 3'h7 && (topP8 & groupMask) < (runP8 & groupMask));

    // running interrupt; completion of the running id ends it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
            runId   <= SpuriousId;
            runPrio <= 4'hf;
        end else if (ackHw || ackSoft) begin
            running <= 1'b1;
            runId   <= ackId;
            runPrio <= irqPrio[ackId[5:0]];
        end else if (wr && pready && paddr == OffsCompletion &&
                     pwdata[IdMsb:IdLsb] == runId) begin
            running <= 1'b0;
            runId   <= SpuriousId;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cpuIrqReq <= 1'b0;
        else
            cpuIrqReq <= cpuEnable && topValid &&
                         topPrio < prioThresh &&
                         preempts;
    end

    // read mux; source field stays zero with a single core
    logic [31:0] rdVal;
    always_comb begin
        rdVal = 32'h00000000;
        case (paddr)
            OffsCpuCtrl:    rdVal[0] = cpuEnable;
            OffsPrioThresh: rdVal[PrioLsb +: 4] = prioThresh;
            OffsGroupSplit: rdVal[2:0] = groupSplit;
            OffsAck, OffsTopPending: begin
                rdVal[IdMsb:IdLsb]   = topValid ? topId : SpuriousId;
                // source only means something for software ids
                if (topValid && topId < 10'(NumIpi))
                    rdVal[SrcMsb:SrcLsb] = OwnCpu;
            end
            OffsActivePrio: rdVal[7:0] = running ?
                                {runPrio, 4'h0} : IdleRunPrio;
            OffsCfgIpi:     rdVal = cfgIpi;
            OffsCfg16:      rdVal = Cfg16Value;
            OffsCfg32:      rdVal = cfg32;
            OffsCfg48:      rdVal = cfg48;
            OffsSoftPending: rdVal = softPend;
            default:        rdVal = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= rdVal;
    end

    threshold_gate_a: assert property (@(posedge clk) disable iff (rst)
        cpuIrqReq |-> $past(topPrio) < $past(prioThresh))
        else $error("request raised at or below threshold");
    equal_prio_a: assert property (@(posedge clk) disable iff (rst)
        (topPrio == prioThresh) |=> !cpuIrqReq)
        else $error("equal priority raised a request");
    disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !cpuEnable |=> !cpuIrqReq)
        else $error("request while interface disabled");
    split_floor_a: assert property (@(posedge clk) disable iff (rst)
        groupSplit >= SplitMin)
        else $error("split below minimum");
    ipi_mask_a: assert property (@(posedge clk) disable iff (rst)
        (cfgIpi & ~IpiCfgWriteMask) == 32'h0)
        else $error("ipi edge bit became writable");
    idle_prio_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !pwrite && paddr == OffsActivePrio &&
         !running) |=> prdata == 32'h000000ff)
        else $error("idle active priority not 0xff");
    spurious_read_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && paddr == OffsTopPending && !topValid)
        |=> prdata[9:0] == 10'h3ff)
        else $error("empty pending not spurious");
    ack_runs_a: assert property (@(posedge clk) disable iff (rst)
        (ackHw || ackSoft) |=> running && runId == $past(ackId))
        else $error("acknowledge did not start running");
    eoi_ends_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsCompletion && running &&
         !ackHw && !ackSoft && pwdata[9:0] == runId) |=> !running)
        else $error("completion did not end interrupt");
    cfg16_const_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && paddr == OffsCfg16) |=> prdata == 32'h0)
        else $error("read-only config changed");
    soft_set_a: assert property (@(posedge clk) disable iff (rst)
        trigSet != 32'h0 |=> (softPend & $past(trigSet)) == $past(trigSet))
        else $error("software trigger not pended");
    others_skip_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsSoftTrig &&
         pwdata[FiltLsb +: 2] == FILT_OTHERS) |-> trigSet == 32'h0)
        else $error("writer reached by the all-but-writer filter");
    resv_skip_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsSoftTrig &&
         pwdata[FiltLsb +: 2] == FILT_RESV) |-> trigSet == 32'h0)
        else $error("reserved filter raised an interrupt");
    self_hit_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsSoftTrig &&
         pwdata[FiltLsb +: 2] == FILT_SELF &&
         pwdata[IdMsb:IdLsb] < 10'(HwBase)) |=> softPend[$past(pwdata[4:0])])
        else $error("self-targeted trigger lost");
    cfg_lands_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsCfg48) |=> cfg48 == $past(pwdata))
        else $error("config write did not land");
    no_preempt_a: assert property (@(posedge clk) disable iff (rst)
        (running && groupSplit == 3'h7) |=> !cpuIrqReq)
        else $error("preempted with split at seven");
    src_zero_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && paddr == OffsAck && topId >= 10'(NumIpi))
        |=> prdata[SrcMsb:SrcLsb] == 3'h0)
        else $error("source field set for a non-software id");
    soft_clear_a: assert property (@(posedge clk) disable iff (rst)
        (ackSoft && !trigSet[ackId[4:0]]) |=> !softPend[$past(ackId[4:0])])
        else $error("acknowledged software interrupt still pending");
    edge_clear_a: assert property (@(posedge clk) disable iff (rst)
        (ackHw && cfgEdge[ackId[4:0]] &&
         !(hwIrqIn[ackId[4:0]] && !hwLast[ackId[4:0]]))
        |=> !hwPend[$past(ackId[4:0])])
        else $error("acknowledged edge interrupt still pending");
    thresh_set_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsPrioThresh)
        |=> prioThresh == $past(pwdata[PrioLsb +: 4]))
        else $error("threshold write did not land");
    enable_set_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsCpuCtrl)
        |=> cpuEnable == $past(pwdata[0]))
        else $error("enable write did not land");
    ipi_store_a: assert property (@(posedge clk) disable iff (rst)
        (wr && pready && paddr == OffsCfgIpi)
        |=> cfgIpi == ($past(pwdata) & IpiCfgWriteMask))
        else $error("ipi config write not masked");
    ack_c: cover property (@(posedge clk) disable iff (rst) ackSoft);
    hw_c: cover property (@(posedge clk) disable iff (rst) ackHw);
    req_c: cover property (@(posedge clk) disable iff (rst) cpuIrqReq);
    split_c: cover property (@(posedge clk) disable iff (rst)
        running && groupSplit == 3'h7 && topValid);
    edge_c: cover property (@(posedge clk) disable iff (rst)
        ackHw && cfgEdge[ackId[4:0]]);
endmodule : irq_dist_cfg_cpu_iface

// *** verification/core_model.sv ***
// behavioural processor core: watches the interrupt request line
`timescale 1ns/1ps
module core_model (
    input  wire logic clk,       // system clock
    input  wire logic rst,       // async reset, high
    input  wire logic cpuIrqReq, // request from the interface
    input  wire logic clrSeen,   // clears the sticky flag
    output logic      seenReq    // request seen since last clear
);
    // sticky, so a one-cycle glitch between bench checks is not missed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seenReq <= 1'b0;
        end else if (clrSeen) begin
            seenReq <= 1'b0;
        end else if (cpuIrqReq === 1'b1) begin
            seenReq <= 1'b1;
        end
    end
endmodule : core_model

// *** verification/tb_irq_dist_cfg_and_cpu_iface.sv ***
// self-checking bench for the interrupt config and cpu interface
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, g); miscompares++; end end
module tb_irq_dist_cfg_and_cpu_iface;
    import irq_ctl_pkg::*;
    logic        clk, rst, psel, penable, pwrite, clrSeen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, hwIrqIn;
    logic        pready, pslverr, cpuIrqReq, seenReq;
    int          miscompares, tests_run, cycles;

    irq_dist_cfg_cpu_iface dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hwIrqIn(hwIrqIn), .cpuIrqReq(cpuIrqReq));
    core_model core (.clk(clk), .rst(rst), .cpuIrqReq(cpuIrqReq),
        .clrSeen(clrSeen), .seenReq(seenReq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        if (miscompares == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    // one idle edge first, so no signal is assigned twice in a step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK($sformatf("rd %h", a), x, r)
    endtask : rchk

    task automatic req(input logic x);
        repeat (3) @(posedge clk);
        `CHK("irq", x, cpuIrqReq)
    endtask : req

    task automatic quiet();
        repeat (2) @(posedge clk);
        clrSeen <= 1'b1;
        @(posedge clk);
        clrSeen <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("seen", 1'b0, seenReq)
    endtask : quiet

    task automatic prio(input int id, input logic [7:0] p);
        wr(OffsIrqPrio, (32'(id) << 16) | 32'(p));
    endtask : prio

    task automatic t_reset();
        rchk(OffsCpuCtrl, 32'h0);
        rchk(OffsPrioThresh, 32'h0);
        rchk(OffsGroupSplit, 32'h3);
        rchk(OffsActivePrio, 32'hff);
        rchk(OffsTopPending, 32'h3ff);
        rchk(OffsCfg16, 32'h0);
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        wr(OffsCfgIpi, '1);
        rchk(OffsCfgIpi, 32'h55555555);
        wr(OffsCfg16, '1);
        rchk(OffsCfg16, Cfg16Value);
        wr(OffsCfg48, 32'ha5a5a5a5);
        rchk(OffsCfg48, 32'ha5a5a5a5);
        wr(OffsCfg32, 32'h5a5a5a5a);
        rchk(OffsCfg32, 32'h5a5a5a5a);
        wr(OffsGroupSplit, 32'h0);
        rchk(OffsGroupSplit, 32'h3);
        wr(OffsGroupSplit, 32'h7);
        rchk(OffsGroupSplit, 32'h7);
        wr(OffsGroupSplit, 32'h3);
        wr(OffsCpuCtrl, '1);
        rchk(OffsCpuCtrl, 32'h1);
        apb(1'b0, 12'h100, 32'h0, r, e);
        `CHK("slverr", 1'b1, e)
        @(posedge clk);
        `CHK("pready drop", 1'b0, pready)
        `CHK("slverr drop", 1'b0, pslverr)
    endtask : t_regs

    task automatic t_soft();
        filter_type f[5] = '{FILT_LIST, FILT_LIST, FILT_OTHERS,
                             FILT_SELF, FILT_RESV};
        logic [7:0] l[5] = '{8'h01, 8'h02, 8'h01, 8'h00, 8'h01};
        // ids stay below 16; only the id 2 list names cpu 1, the rest cpu 0 or none
        for (int i = 0; i < 5; i++) begin
            wr(OffsSoftTrig, {6'h0, f[i], l[i], 6'h0, 10'(i + 1)});
        end
        rchk(OffsSoftPending, 32'h12);
        rchk(OffsTopPending, 32'h1);
        quiet();
    endtask : t_soft

    task automatic t_request();
        wr(OffsCpuCtrl, 32'h0);
        wr(OffsPrioThresh, 32'hf0);
        quiet();
        wr(OffsCpuCtrl, 32'h1);
        req(1'b1);
        rchk(OffsAck, 32'h1);
        rchk(OffsActivePrio, 32'h0);
        rchk(OffsTopPending, 32'h4);
        wr(OffsCompletion, 32'h1);
        rchk(OffsActivePrio, 32'hff);
        prio(4, 8'hf0);
        req(1'b0);
        prio(4, 8'h40);
        rchk(OffsAck, 32'h4);
        prio(2, 8'h20);
        wr(OffsSoftTrig, {6'h0, FILT_SELF, 8'h0, 6'h0, 10'h2});
        req(1'b1);
        wr(OffsGroupSplit, 32'h7);
        req(1'b0);
        wr(OffsCompletion, 32'h4);
        req(1'b1);
        rchk(OffsAck, 32'h2);
        wr(OffsCompletion, 32'h2);
        wr(OffsGroupSplit, 32'h3);
    endtask : t_request

    task automatic t_hw();
        wr(OffsCfg32, 32'h0);
        hwIrqIn[0] <= 1'b1;
        rchk(OffsTopPending, 32'd32);
        hwIrqIn[0] <= 1'b0;
        rchk(OffsTopPending, 32'h3ff);
        wr(OffsCfg32, 32'h2);
        @(posedge clk);
        hwIrqIn[0] <= 1'b1;
        @(posedge clk);
        hwIrqIn[0] <= 1'b0;
        req(1'b1);
        rchk(OffsAck, 32'd32);
        wr(OffsCompletion, 32'd32);
        rchk(OffsTopPending, 32'h3ff);
    endtask : t_hw

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; hwIrqIn = 32'h0; clrSeen = 1'b0;
        miscompares = 0; tests_run = 0; cycles = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_soft();
        t_request();
        t_hw();
        results();
    end
endmodule : tb_irq_dist_cfg_and_cpu_iface
